// File: src/ssc_defines.svh
// constants of the software standby control block
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH
`define SSC_ADDR_CTRL      4'h0
`define SSC_ADDR_STATUS    4'h1
`define SSC_CTRL_RESET     8'h08
`define SSC_CTRL_WMASK     8'hF9
`define SSC_WAIT_LSB       4
`define SSC_HOLD_BIT       3
`define SSC_EXT_WAKE_BIT   0
`define SSC_WAIT_8192      32'd8192
`define SSC_WAIT_16384     32'd16384
`define SSC_WAIT_32768     32'd32768
`define SSC_WAIT_65536     32'd65536
`define SSC_WAIT_131072    32'd131072
`define SSC_WAIT_262144    32'd262144
`define SSC_WAIT_16        32'd16
`endif

// File: src/ssc_pkg.sv
// types of the software standby control block
package ssc_pkg;
    // one-hot sequencer states
    typedef enum logic [2:0] {
        SSC_RUN   = 3'b001,
        SSC_SLEEP = 3'b010,
        SSC_SETTLE = 3'b100
    } ssc_state_t;
endpackage

// File: src/ssc_standby_ctrl.sv
// software standby control: register, wake selection, settling counter, bus hold
//
// Summary of operation
// R1 - wait field resets to 000, 8192 states
// R2 - codes 001..101 give 16384..262144 states
// R3 - code 111 gives 16 states; 110 reserved
// R4 - hold bit governs address bus and strobes
// R5 - hold bit 0 floats bus during standby
// R6 - hold bit 1 (reset) keeps bus driven
// R7 - bits 2 and 1 ignore writes, read 0
// R8 - nmi and irq 0..2 always wake
// R9 - ext select 0: irq 3..7 cannot wake
// R10 - ext select 1: irq 3..7 also wake
// R11 - count selected states, then resume clocks
`timescale 1ns/10ps
`include "ssc_defines.svh"

module ssc_standby_ctrl
    import ssc_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    input  wire logic              sleep_req,
    input  wire logic              nmi_wake,
    input  wire logic [2:0]        ext_interrupt_inputs_0_to_2,
    input  wire logic [4:0]        ext_interrupt_inputs_3_to_7,
    output logic                   standby_active,
    output logic                   clocks_run,
    output logic                   resume_pulse,
    output logic                   addr_bus_oe,
    output logic                   chip_select_outputs_oe,
    output logic                   address_strobe_oe,
    output logic                   read_strobe_oe,
    output logic                   upper_write_strobe_oe,
    output logic                   lower_write_strobe_oe,
    output logic                   column_strobe_oe
);

    logic [7:0]  ctrl_q;        // standby control register
    logic [7:0]  rdata_q;       // registered read data
    ssc_state_t  state_q;       // sequencer state
    logic [18:0] cnt_q;         // settling counter
    logic        resume_q;      // one-cycle resume strobe
    logic        wake;          // a valid wake source is present
    logic        bus_float;     // drivers released
    logic [18:0] settle_len_q;  // helper: consecutive cycles spent settling

    // settling length in states for each wait code
    function automatic logic [18:0] wait_states(input logic [2:0] code);
        logic [31:0] n;
        n = `SSC_WAIT_8192;                              // [R1]
        unique case (code)
            3'h1:    n = `SSC_WAIT_16384;                // [R2]
            3'h2:    n = `SSC_WAIT_32768;                // [R2]
            3'h3:    n = `SSC_WAIT_65536;                // [R2]
            3'h4:    n = `SSC_WAIT_131072;               // [R2]
            3'h5:    n = `SSC_WAIT_262144;               // [R2]
            3'h7:    n = `SSC_WAIT_16;                   // [R3]
            // reserved 110 falls back to the longest wait, the safe side
            3'h6:    n = `SSC_WAIT_262144;
            default: n = `SSC_WAIT_8192;
        endcase
        return n[18:0];
    endfunction

    // register write; reserved bits masked so they stay zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= `SSC_CTRL_RESET;                   // [R1] [R6] [R9]
        end else if (reg_wr && reg_addr == `SSC_ADDR_CTRL) begin
            ctrl_q <= reg_wdata & `SSC_CTRL_WMASK;       // [R7]
        end
    end

    // read data stands one cycle after the read strobe, zero otherwise
    // zero outside the read cycle lets several readers share one or-ed bus
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `SSC_ADDR_CTRL) begin
                rdata_q <= ctrl_q;                       // [R7]
            end else if (reg_addr == `SSC_ADDR_STATUS) begin
                rdata_q <= {5'h00, state_q};
            end else begin
                rdata_q <= 8'h00;                        // unmapped reads zero
            end
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign reg_rdata = rdata_q;

    // wake qualification: low group always, high group only when selected
    // inputs arrive already qualified upstream; no edge detection here
    assign wake = nmi_wake || (|ext_interrupt_inputs_0_to_2)            // [R8]
                  || (ctrl_q[`SSC_EXT_WAKE_BIT]
                      && (|ext_interrupt_inputs_3_to_7));               // [R9] [R10]

    // sequencer: run, sleep, settle with oscillator running
    // reserved code cannot stall it: the decode maps it to the longest wait
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= SSC_RUN;
        end else begin
            unique case (state_q)
                SSC_RUN: begin
                    if (sleep_req) begin
                        state_q <= SSC_SLEEP;
                    end
                end
                SSC_SLEEP: begin
                    if (wake) begin
                        state_q <= SSC_SETTLE;           // [R11]
                    end
                end
                SSC_SETTLE: begin
                    if (cnt_q == 19'h00001) begin
                        state_q <= SSC_RUN;              // [R11]
                    end
                end
                default: state_q <= SSC_RUN;
            endcase
        end
    end

    // settling counter, loaded with the wait chosen at wake time
    // latched at the wake edge, so a later write cannot stretch or cut it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 19'h00000;
        end else if (state_q == SSC_SLEEP && wake) begin
            cnt_q <= wait_states(ctrl_q[`SSC_WAIT_LSB +: 3]);  // [R11]
        end else if (state_q == SSC_SETTLE && cnt_q != 19'h00000) begin
            cnt_q <= cnt_q - 19'h00001;
        end
    end

    // resume strobe in the first run cycle, registered from the last settling state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            resume_q <= 1'b0;
        end else begin
            resume_q <= (state_q == SSC_SETTLE) && (cnt_q == 19'h00001);
        end
    end

    assign standby_active = (state_q != SSC_RUN);
    assign clocks_run     = (state_q == SSC_RUN);                        // [R11]
    assign resume_pulse   = resume_q;

    // helper for the settle checks: counts consecutive settle cycles, so the
    // length is asserted on a number instead of a long repetition
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            settle_len_q <= 19'h00000;
        end else if (state_q == SSC_SETTLE) begin
            settle_len_q <= settle_len_q + 19'h00001;   // longest wait fits, no wrap
        end else begin
            settle_len_q <= 19'h00000;                  // cleared outside settle
        end
    end

    // bus drivers released only in standby with hold bit clear
    // trade-off: all seven groups share one enable and cannot float apart
    assign bus_float = standby_active && !ctrl_q[`SSC_HOLD_BIT];        // [R5] [R6]
    assign addr_bus_oe            = !bus_float;                          // [R4]
    assign chip_select_outputs_oe = !bus_float;                          // [R4]
    assign address_strobe_oe      = !bus_float;                          // [R4]
    assign read_strobe_oe         = !bus_float;                          // [R4]
    assign upper_write_strobe_oe  = !bus_float;                          // [R4]
    assign lower_write_strobe_oe  = !bus_float;                          // [R4]
    assign column_strobe_oe       = !bus_float;                          // [R4]

    // reset values of the control register
    a_reset_value: assert property (@(posedge clk)
        $rose(nrst) |-> ctrl_q == 8'h08)                                 // [R1]
        else $error("control reset value wrong");

    a_reserved_zero: assert property (@(posedge clk) disable iff (!nrst)
        ctrl_q[2:1] == 2'b00)                                            // [R7]
        else $error("reserved bits not zero");

    a_wait_16: assert property (@(posedge clk) disable iff (!nrst)
        (state_q == SSC_SLEEP && wake && ctrl_q[6:4] == 3'h7)
        |=> cnt_q == 19'd16)                                             // [R3]
        else $error("code 7 wait not 16");

    a_wait_long: assert property (@(posedge clk) disable iff (!nrst)
        (state_q == SSC_SLEEP && wake && ctrl_q[6:4] == 3'h1)
        |=> cnt_q == 19'd16384)                                          // [R2]
        else $error("code 1 wait not 16384");

    // short settle: wake with code 7, sixteen settle cycles, then run
    sequence s_short_wake;
        state_q == SSC_SLEEP && wake && ctrl_q[6:4] == 3'h7;
    endsequence
    sequence s_short_settle;
        !clocks_run ##15 (!clocks_run && settle_len_q == 19'd15);
    endsequence
    a_settle_len: assert property (@(posedge clk) disable iff (!nrst)
        s_short_wake |=> s_short_settle ##1 clocks_run)                  // [R11]
        else $error("settle length wrong");

    a_low_wake: assert property (@(posedge clk) disable iff (!nrst)
        (state_q == SSC_SLEEP && (nmi_wake || |ext_interrupt_inputs_0_to_2))
        |=> state_q == SSC_SETTLE)                                       // [R8]
        else $error("nmi or low irq did not wake");

    a_high_masked: assert property (@(posedge clk) disable iff (!nrst)
        (state_q == SSC_SLEEP && !ctrl_q[0] && !nmi_wake
         && ext_interrupt_inputs_0_to_2 == 3'h0)
        |=> state_q != SSC_SETTLE)                                       // [R9]
        else $error("masked irq woke the block");

    a_high_wake: assert property (@(posedge clk) disable iff (!nrst)
        (state_q == SSC_SLEEP && ctrl_q[0] && |ext_interrupt_inputs_3_to_7)
        |=> state_q == SSC_SETTLE)                                       // [R10]
        else $error("selected irq did not wake");

    a_bus_float: assert property (@(posedge clk) disable iff (!nrst)
        (standby_active && !ctrl_q[3]) |-> !addr_bus_oe && !column_strobe_oe) // [R5]
        else $error("bus not floated");

    a_bus_hold: assert property (@(posedge clk) disable iff (!nrst)
        ctrl_q[3] |-> addr_bus_oe && chip_select_outputs_oe)            // [R6]
        else $error("bus released with hold set");

    // further checks of the settle path and the register port
    // default code loads the shortest regular wait
    a_wait_default: assert property (@(posedge clk) disable iff (!nrst) // [R1]
        (state_q == SSC_SLEEP && wake && ctrl_q[6:4] == 3'h0)
        |=> cnt_q == 19'd8192)
        else $error("code 0 wait not 8192");

    // settling: the counter steps down by one each cycle until the last state
    a_cnt_step: assert property (@(posedge clk) disable iff (!nrst)      // [R11]
        (state_q == SSC_SETTLE && cnt_q > 19'h00001)
        |=> state_q == SSC_SETTLE && cnt_q == $past(cnt_q) - 19'h00001)
        else $error("settle counter skipped");

    a_settle_ends: assert property (@(posedge clk) disable iff (!nrst)   // [R11]
        (state_q == SSC_SETTLE && cnt_q == 19'h00001)
        |=> clocks_run && resume_pulse)
        else $error("settle did not end");

    // resume strobe: one cycle, in the first run cycle after settling
    a_resume_pulse: assert property (@(posedge clk) disable iff (!nrst)  // [R11]
        resume_pulse |-> clocks_run && $past(state_q) == SSC_SETTLE)
        else $error("resume outside settle exit");

    a_resume_single: assert property (@(posedge clk) disable iff (!nrst) // [R11]
        resume_pulse |=> !resume_pulse)
        else $error("resume longer than one cycle");

    // entering and leaving standby follows run, sleep, settle only
    a_sleep_entry: assert property (@(posedge clk) disable iff (!nrst)
        (state_q == SSC_RUN && sleep_req) |=> state_q == SSC_SLEEP)
        else $error("sleep request not taken");

    a_run_no_wake: assert property (@(posedge clk) disable iff (!nrst)
        state_q == SSC_RUN |=> state_q != SSC_SETTLE)
        else $error("wake taken outside standby");

    // all seven groups of outputs float together and drive together
    a_group_float: assert property (@(posedge clk) disable iff (!nrst)   // [R4] [R5]
        (state_q != SSC_RUN && !ctrl_q[`SSC_HOLD_BIT])
        |-> {addr_bus_oe, chip_select_outputs_oe, address_strobe_oe, read_strobe_oe,
             upper_write_strobe_oe, lower_write_strobe_oe, column_strobe_oe} == 7'h00)
        else $error("bus group not floated");

    a_group_drive: assert property (@(posedge clk) disable iff (!nrst)   // [R4] [R6]
        (state_q == SSC_RUN || ctrl_q[`SSC_HOLD_BIT])
        |-> {addr_bus_oe, chip_select_outputs_oe, address_strobe_oe, read_strobe_oe,
             upper_write_strobe_oe, lower_write_strobe_oe, column_strobe_oe} == 7'h7F)
        else $error("bus group released");

    // register port: write mask, read-back, status and idle read data
    a_write_mask: assert property (@(posedge clk) disable iff (!nrst)    // [R7]
        (reg_wr && reg_addr == `SSC_ADDR_CTRL)
        |=> ctrl_q[2:1] == 2'b00 && ctrl_q[7:3] == $past(reg_wdata[7:3])
            && ctrl_q[0] == $past(reg_wdata[0]))
        else $error("control write not masked");

    a_ctrl_read: assert property (@(posedge clk) disable iff (!nrst)     // [R7]
        (reg_rd && reg_addr == `SSC_ADDR_CTRL) |=> reg_rdata == $past(ctrl_q))
        else $error("control read-back wrong");

    a_status_read: assert property (@(posedge clk) disable iff (!nrst)
        (reg_rd && reg_addr == `SSC_ADDR_STATUS)
        |=> reg_rdata == {5'h00, $past(state_q)})
        else $error("status read-back wrong");

    a_read_idle: assert property (@(posedge clk) disable iff (!nrst)
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");

endmodule

// File: dv/test_software_standby_control.sv
// self-checking bench of the software standby control block
`timescale 1ns/10ps

module test_software_standby_control;
    logic        clk = 1'b0;       // 100 MHz system clock
    logic        nrst = 1'b0;      // async reset, active low
    logic [3:0]  reg_addr = 4'h0;  // register address
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic        sleep_req = 1'b0; // sleep instruction
    logic        nmi_wake = 1'b0;
    logic [2:0]  irq_lo = 3'h0;    // wake inputs 0..2
    logic [4:0]  irq_hi = 5'h00;   // wake inputs 3..7
    logic        standby_active;
    logic        clocks_run;
    logic        resume_pulse;
    logic [6:0]  oe;               // all bus output enables
    int          errors = 0;
    int          n_compared = 0;
    int          cyc = 0;

    ssc_standby_ctrl uut (
        .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sleep_req(sleep_req), .nmi_wake(nmi_wake),
        .ext_interrupt_inputs_0_to_2(irq_lo), .ext_interrupt_inputs_3_to_7(irq_hi),
        .standby_active(standby_active), .clocks_run(clocks_run),
        .resume_pulse(resume_pulse), .addr_bus_oe(oe[6]),
        .chip_select_outputs_oe(oe[5]), .address_strobe_oe(oe[4]),
        .read_strobe_oe(oe[3]), .upper_write_strobe_oe(oe[2]),
        .lower_write_strobe_oe(oe[1]), .column_strobe_oe(oe[0]));

    // free-running clock
    always #5 clk = ~clk;

    // closing report, the only exit
    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // hang guard: longest run is two long waits plus short ones
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read data is looked at only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk({24'h0, reg_rdata}, {24'h0, exp});
    endtask

    // enter standby, offer a wake that must be ignored, then a real one
    task automatic standby(input logic [7:0] ctrl, input logic [4:0] dud, input logic [2:0] lo,
                           input logic [4:0] hi, input logic nmi, input int n);
        int k;
        wr(4'h0, ctrl);
        @(posedge clk);
        sleep_req <= 1'b1;
        @(posedge clk);
        sleep_req <= 1'b0;
        irq_hi <= dud;
        #1;
        chk({31'h0, standby_active}, 32'h1);
        chk({25'h0, oe}, ctrl[3] ? 32'h7F : 32'h00);
        repeat (20) @(posedge clk);
        irq_hi <= 5'h00;
        #1;
        chk({30'h0, clocks_run, standby_active}, 32'h1);
        @(posedge clk);
        irq_lo <= lo;
        irq_hi <= hi;
        nmi_wake <= nmi;
        @(posedge clk);
        irq_lo <= 3'h0;
        irq_hi <= 5'h00;
        nmi_wake <= 1'b0;
        k = 0;
        // settle time counted from the edge that took the wake
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (clocks_run !== 1'b1 && k < n + 8);
        chk(k, n);
        chk({24'h0, resume_pulse, oe}, 32'hFF);
        $display("standby test done, code %h wait %0d", ctrl[6:4], n);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(4'h0, 8'h08);
        rd_chk(4'h1, 8'h01);
        rd_chk(4'hF, 8'h00);
        wr(4'h0, 8'hFF);
        rd_chk(4'h0, 8'hF9);
        wr(4'h5, 8'h00);
        rd_chk(4'h5, 8'h00);
        rd_chk(4'h0, 8'hF9);
        $display("register test done");
        standby(8'h70, 5'h00, 3'h0, 5'h00, 1'b1, 16);
        standby(8'h78, 5'h1F, 3'h4, 5'h00, 1'b0, 16);
        standby(8'h79, 5'h00, 3'h0, 5'h10, 1'b0, 16);
        standby(8'h71, 5'h00, 3'h1, 5'h00, 1'b0, 16);
        standby(8'h08, 5'h00, 3'h2, 5'h00, 1'b0, 8192);
        standby(8'h18, 5'h00, 3'h0, 5'h00, 1'b1, 16384);
        give_verdict();
    end
endmodule
